// *** rtl/alu_consts.svh ***
// Constants for the integer logic, shift and copy datapath slice.
// Assumes byte addressing on a 32-bit Avalon-MM register bus.
`ifndef ALU_CONSTS_SVH
`define ALU_CONSTS_SVH

// Register bus geometry
`define ALU_ADDR_W 5
`define ALU_DATA_W 32

// Register byte offsets, one aligned word each
`define OFS_FIRST_OPERAND 5'h00
`define OFS_SOURCE 5'h04
`define OFS_SHIFT_AMOUNT 5'h08
`define OFS_CONTROL 5'h0C
`define OFS_FLAGS 5'h10
`define OFS_RESULT 5'h14
`define OFS_PROGRAM_COUNTER 5'h18
`define OFS_STATUS 5'h1C

// Reset values
`define RST_WORD 32'h0000_0000
`define RST_FLAGS 4'h0

// Field positions inside the status word
`define STATUS_WROTE_DEST 0
`define STATUS_REDIRECT 1

// Shifter limits
`define SHIFT_FULL 8'h20
`define SHIFT_BEYOND 8'h21
`define SHIFT_BYTE_W 8
`define CLZ_ALL_ZERO 6'h20

`endif

// *** rtl/alu_pkg.sv ***
// Types shared by the datapath slice: operation codes, control word and flags.
// Assumes the constants header is included by the design file.
package alu_pkg;

	// Operation selected by the control word
	typedef enum logic [3:0] {
		BITWISE_CONJUNCTION = 4'h0,
		BITWISE_DISJUNCTION = 4'h1,
		BITWISE_EXCLUSIVE_DISJUNCTION = 4'h2,
		BIT_CLEAR_OP = 4'h3,
		DISJUNCTION_WITH_COMPLEMENT = 4'h4,
		COPY_OP = 4'h5,
		INVERTED_COPY = 4'h6,
		WIDE_IMMEDIATE_COPY = 4'h7,
		LEADING_ZERO_COUNT = 4'h8,
		COMPARE_BY_SUBTRACT = 4'h9,
		COMPARE_BY_ADD = 4'hA,
		ADD_WITH_CARRY = 4'hB,
		SUBTRACT_WITH_BORROW = 4'hC
	} alu_op_t;

	// Shift applied to the source register
	typedef enum logic [1:0] {
		LOGIC_SHIFT_LEFT = 2'h0,
		LOGIC_SHIFT_RIGHT = 2'h1,
		ARITH_SHIFT_RIGHT = 2'h2,
		ROTATE_RIGHT = 2'h3
	} shift_kind_t;

	// Control word layout, most significant field first
	typedef struct packed {
		logic [15:0] wide_immediate;
		logic [4:0] imm_amount;
		logic dest_is_pc;
		logic set_flags;
		logic rotate_through_carry;
		logic amount_by_reg;
		logic reserved;
		shift_kind_t shift_kind;
		alu_op_t op;
	} ctrl_t;

	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
	} flags_t;

	typedef struct packed {
		logic [31:0] value;
		logic carry;
	} shift_res_t;

endpackage : alu_pkg

// *** rtl/integer_logic_shift_move_alu.sv ***
// Integer logic, shift, count, compare and copy datapath with Avalon-MM registers.
// Assumes a decoder loads operands, then writes the control word to execute.
// Notes on behaviour
// [RULE1] Conjunction, disjunction, exclusive disjunction combine first operand with flexible operand.
// [RULE2] Bit clear ANDs first operand with complemented flexible operand.
// [RULE3] Disjunction with complement ORs first operand with complemented flexible operand.
// [RULE4] Logical and copy ops with flag update set N, Z, shifter C; V kept.
// [RULE5] Register shift amount is the low byte only, 0 to 255.
// [RULE6] Immediate amounts: 1..32 for right shifts, 0..31 for left shift, rotate.
// [RULE7] Rotate through carry moves the source right by one bit.
// [RULE8] Shifts write only the destination; the source register stays unchanged.
// [RULE9] Shifts with flag update set N, Z, C last bit out; zero amount keeps C.
// [RULE10] Leading zero count gives 32 for zero, zero when bit 31 set.
// [RULE11] Leading zero count never changes any flag.
// [RULE12] Compare by subtract computes first minus flexible, writes no register.
// [RULE13] Compare by add computes first plus flexible, writes no register.
// [RULE14] Both compares always update N, Z, C and V.
// [RULE15] Copy places the shifted flexible operand into the destination.
// [RULE16] Wide immediate copy takes an unsigned 16-bit value, else like copy.
// [RULE17] Inverted copy writes the complement of the flexible operand.
// [RULE18] Copy with register shift equals the matching shift operation exactly.
// [RULE19] Copy to the program counter clears bit 0 and redirects there.
// [RULE20] Decoder uses stack pointer or PC only unshifted and without flag update.
// [RULE21] Add and subtract with carry consume the stored carry flag.
// [RULE22] Subtract with borrow takes one more off when carry is clear.
// [RULE23] Rotate through carry puts carry in bit 31, bit 0 into C.
// [RULE24] Without flag update, logical, shift and copy ops keep all flags.
`timescale 1ns/1ns
`include "alu_consts.svh"
`default_nettype none

module integer_logic_shift_move_alu
	import alu_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [`ALU_ADDR_W-1:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [`ALU_DATA_W-1:0] writedata_i,
	input wire logic [3:0] byteenable_i,
	output logic [`ALU_DATA_W-1:0] readdata_o,
	output logic waitrequest_o,
	output logic [31:0] pc_o,
	output logic redirect_o,
	output logic [3:0] flags_o
);

	// Register state
	logic [31:0] first_operand_q;
	logic [31:0] source_q;
	logic [31:0] shift_amount_q;
	ctrl_t ctrl_q;
	flags_t flags_q;
	logic [31:0] result_q;
	logic [31:0] pc_q;
	logic [1:0] status_q;
	logic exec_q;
	logic redirect_q;
	logic ack_q;
	logic [31:0] readdata_q;

	// Datapath values
	logic [7:0] amount;
	shift_res_t shifted;
	logic [31:0] flex_val;
	logic flex_carry;
	logic [32:0] sum;
	logic [31:0] addend;
	logic add_cin;
	logic [31:0] alu_val;
	flags_t alu_flags;
	logic writes_dest;
	logic bus_wr;
	logic is_logic;

	// Lane-wise merge of a bus write into a stored word
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] out;
		out = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				out[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return out;
	endfunction : be_merge

	// Barrel shifter with carry out; a zero amount passes value and carry through
	function automatic shift_res_t shift_f(input logic [31:0] src, input shift_kind_t kind,
		input logic [7:0] amt, input logic cin);
		shift_res_t r;
		logic [63:0] w;
		logic [7:0] a;
		r.value = src;
		r.carry = cin;
		w = 64'h0;
		a = (amt > `SHIFT_FULL) ? `SHIFT_FULL : amt;
		if (amt != 8'h00) begin // RULE9
			case (kind)
				LOGIC_SHIFT_LEFT: begin
					w = {32'h0000_0000, src} << a[5:0];
					r.value = (amt >= `SHIFT_BEYOND) ? 32'h0000_0000 : w[31:0];
					r.carry = (amt >= `SHIFT_BEYOND) ? 1'b0 : w[32];
				end
				LOGIC_SHIFT_RIGHT: begin
					w = {src, 32'h0000_0000} >> a[5:0];
					r.value = (amt >= `SHIFT_BEYOND) ? 32'h0000_0000 : w[63:32];
					r.carry = (amt >= `SHIFT_BEYOND) ? 1'b0 : w[31];
				end
				ARITH_SHIFT_RIGHT: begin
					// Amounts past 32 saturate: all sign bits, carry is the sign
					w = $signed({src, 32'h0000_0000}) >>> a[5:0];
					r.value = w[63:32];
					r.carry = w[31];
				end
				ROTATE_RIGHT: begin
					w = {src, src} >> amt[4:0];
					r.value = w[31:0];
					r.carry = w[31];
				end
				default: begin
					r.value = src;
				end
			endcase
		end
		return r;
	endfunction : shift_f

	// Leading zero count over 32 bits
	function automatic logic [5:0] clz_f(input logic [31:0] v);
		logic [5:0] cnt;
		logic found;
		cnt = 6'h00;
		found = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			if (v[i]) begin
				found = 1'b1;
			end else if (!found) begin
				cnt = cnt + 6'h01;
			end
		end
		return cnt;
	endfunction : clz_f

	// Shift amount: low byte of the amount register, or the immediate field
	always_comb begin
		if (ctrl_q.amount_by_reg) begin
			amount = shift_amount_q[`SHIFT_BYTE_W-1:0]; // RULE5
		end else if (ctrl_q.imm_amount == 5'h00 &&
			(ctrl_q.shift_kind == LOGIC_SHIFT_RIGHT || ctrl_q.shift_kind == ARITH_SHIFT_RIGHT)) begin
			amount = `SHIFT_FULL; // RULE6
		end else begin
			amount = {3'h0, ctrl_q.imm_amount}; // RULE6
		end
	end

	// Flexible second operand, shared by every operation except leading zero count so copies match shifts
	always_comb begin
		shifted = shift_f(source_q, ctrl_q.shift_kind, amount, flags_q.c); // RULE18
		flex_val = shifted.value;
		flex_carry = shifted.carry;
		if (ctrl_q.rotate_through_carry) begin
			flex_val = {flags_q.c, source_q[31:1]}; // RULE7 RULE23
			flex_carry = source_q[0]; // RULE23
		end
		if (ctrl_q.op == WIDE_IMMEDIATE_COPY) begin
			flex_val = {16'h0000, ctrl_q.wide_immediate}; // RULE16
			flex_carry = flags_q.c;
		end
	end

	// Adder for compares and carry-chained add and subtract
	always_comb begin
		addend = flex_val;
		add_cin = 1'b0;
		case (ctrl_q.op)
			COMPARE_BY_SUBTRACT: begin
				addend = ~flex_val; // RULE12
				add_cin = 1'b1;
			end
			COMPARE_BY_ADD: begin
				add_cin = 1'b0; // RULE13
			end
			ADD_WITH_CARRY: begin
				add_cin = flags_q.c; // RULE21
			end
			SUBTRACT_WITH_BORROW: begin
				// Clear carry means a borrow is pending: one extra taken off
				addend = ~flex_val; // RULE22
				add_cin = flags_q.c; // RULE21 RULE22
			end
			default: begin
				addend = flex_val;
			end
		endcase
		sum = {1'b0, first_operand_q} + {1'b0, addend} + {32'h0000_0000, add_cin};
	end

	// Result and next flags per operation
	always_comb begin
		alu_val = flex_val;
		alu_flags = flags_q;
		writes_dest = 1'b1;
		is_logic = 1'b1;
		case (ctrl_q.op)
			BITWISE_CONJUNCTION: alu_val = first_operand_q & flex_val; // RULE1
			BITWISE_DISJUNCTION: alu_val = first_operand_q | flex_val; // RULE1
			BITWISE_EXCLUSIVE_DISJUNCTION: alu_val = first_operand_q ^ flex_val; // RULE1
			BIT_CLEAR_OP: alu_val = first_operand_q & ~flex_val; // RULE2
			DISJUNCTION_WITH_COMPLEMENT: alu_val = first_operand_q | ~flex_val; // RULE3
			COPY_OP: alu_val = flex_val; // RULE15
			INVERTED_COPY: alu_val = ~flex_val; // RULE17
			WIDE_IMMEDIATE_COPY: alu_val = flex_val; // RULE16
			LEADING_ZERO_COUNT: begin
				alu_val = {26'h000_0000, clz_f(source_q)}; // RULE10
				is_logic = 1'b0;
			end
			COMPARE_BY_SUBTRACT, COMPARE_BY_ADD, ADD_WITH_CARRY, SUBTRACT_WITH_BORROW: begin
				alu_val = sum[31:0];
				is_logic = 1'b0;
			end
			default: begin
				alu_val = flex_val;
				writes_dest = 1'b0;
				is_logic = 1'b0;
			end
		endcase
		if (ctrl_q.op == COMPARE_BY_SUBTRACT || ctrl_q.op == COMPARE_BY_ADD) begin
			writes_dest = 1'b0; // RULE12 RULE13
		end
		// Flag effects
		if (is_logic && ctrl_q.set_flags) begin
			alu_flags.n = alu_val[31]; // RULE4 RULE9
			alu_flags.z = (alu_val == 32'h0000_0000); // RULE4 RULE9
			alu_flags.c = flex_carry; // RULE4 RULE9
		end
		if (ctrl_q.op == COMPARE_BY_SUBTRACT || ctrl_q.op == COMPARE_BY_ADD ||
			((ctrl_q.op == ADD_WITH_CARRY || ctrl_q.op == SUBTRACT_WITH_BORROW) && ctrl_q.set_flags)) begin
			alu_flags.n = sum[31]; // RULE14
			alu_flags.z = (sum[31:0] == 32'h0000_0000); // RULE14
			alu_flags.c = sum[32]; // RULE14
			alu_flags.v = (first_operand_q[31] == addend[31]) && (sum[31] != first_operand_q[31]); // RULE14
		end
	end

	// Avalon slave: one wait cycle per access, effect at the releasing edge
	assign waitrequest_o = (read_i | write_i) & ~ack_q;
	assign bus_wr = write_i & ack_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (read_i | write_i) & ~ack_q;
		end
	end

	// Read data registered during the wait cycle; unmapped words read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			readdata_q <= `RST_WORD;
		end else if (read_i && !ack_q) begin
			case (address_i)
				`OFS_FIRST_OPERAND: readdata_q <= first_operand_q;
				`OFS_SOURCE: readdata_q <= source_q;
				`OFS_SHIFT_AMOUNT: readdata_q <= shift_amount_q;
				`OFS_CONTROL: readdata_q <= ctrl_q;
				`OFS_FLAGS: readdata_q <= {28'h000_0000, flags_q};
				`OFS_RESULT: readdata_q <= result_q;
				`OFS_PROGRAM_COUNTER: readdata_q <= pc_q;
				`OFS_STATUS: readdata_q <= {30'h0000_0000, status_q};
				default: readdata_q <= `RST_WORD;
			endcase
		end
	end
	assign readdata_o = readdata_q;

	// Operand registers; execution never writes them back
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			first_operand_q <= `RST_WORD;
			source_q <= `RST_WORD;
			shift_amount_q <= `RST_WORD;
		end else if (bus_wr) begin
			if (address_i == `OFS_FIRST_OPERAND) first_operand_q <= be_merge(first_operand_q, writedata_i, byteenable_i);
			if (address_i == `OFS_SOURCE) source_q <= be_merge(source_q, writedata_i, byteenable_i); // RULE8
			if (address_i == `OFS_SHIFT_AMOUNT) shift_amount_q <= be_merge(shift_amount_q, writedata_i, byteenable_i);
		end
	end

	// Control word; a write to it launches one execution in the next cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= ctrl_t'(`RST_WORD);
			exec_q <= 1'b0;
		end else begin
			exec_q <= bus_wr && (address_i == `OFS_CONTROL);
			if (bus_wr && address_i == `OFS_CONTROL) begin
				ctrl_q <= ctrl_t'(be_merge(ctrl_q, writedata_i, byteenable_i));
			end
		end
	end

	// Flags: execution beats a software write in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags_q <= flags_t'(`RST_FLAGS);
		end else if (exec_q) begin
			flags_q <= alu_flags; // RULE11 RULE24
		end else if (bus_wr && address_i == `OFS_FLAGS && byteenable_i[0]) begin
			flags_q <= flags_t'(writedata_i[3:0]);
		end
	end

	// Destination write or program counter redirect
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			result_q <= `RST_WORD;
			pc_q <= `RST_WORD;
			redirect_q <= 1'b0;
			status_q <= 2'h0;
		end else begin
			redirect_q <= 1'b0;
			if (exec_q) begin
				status_q[`STATUS_WROTE_DEST] <= writes_dest && !ctrl_q.dest_is_pc;
				status_q[`STATUS_REDIRECT] <= writes_dest && ctrl_q.dest_is_pc;
				if (writes_dest && ctrl_q.dest_is_pc) begin
					// Unshifted, no flag update assumed; no check made here
					pc_q <= {alu_val[31:1], 1'b0}; // RULE19 RULE20
					redirect_q <= 1'b1; // RULE19
				end else if (writes_dest) begin
					result_q <= alu_val; // RULE8 RULE15
				end
			end
		end
	end

	assign pc_o = pc_q;
	assign redirect_o = redirect_q;
	assign flags_o = flags_q;

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_conj;
		exec_q && ctrl_q.op == BITWISE_CONJUNCTION && !ctrl_q.dest_is_pc |=> result_q == $past(first_operand_q & flex_val);
	endproperty
	a_conj: assert property (p_conj) else $error("conjunction result wrong"); // RULE1

	property p_bic;
		exec_q && ctrl_q.op == BIT_CLEAR_OP && !ctrl_q.dest_is_pc |=> result_q == $past(first_operand_q & ~flex_val);
	endproperty
	a_bic: assert property (p_bic) else $error("bit clear result wrong"); // RULE2

	property p_orn;
		exec_q && ctrl_q.op == DISJUNCTION_WITH_COMPLEMENT && !ctrl_q.dest_is_pc
			|=> result_q == $past(first_operand_q | ~flex_val);
	endproperty
	a_orn: assert property (p_orn) else $error("disjunction with complement wrong"); // RULE3

	property p_logic_v;
		exec_q && is_logic |=> flags_q.v == $past(flags_q.v);
	endproperty
	a_logic_v: assert property (p_logic_v) else $error("logical op changed V"); // RULE4

	property p_zero_amt;
		exec_q && is_logic && amount == 8'h00 && !ctrl_q.rotate_through_carry && ctrl_q.op != WIDE_IMMEDIATE_COPY
			|=> flags_q.c == $past(flags_q.c);
	endproperty
	a_zero_amt: assert property (p_zero_amt) else $error("zero shift loaded carry"); // RULE9

	property p_clz;
		exec_q && ctrl_q.op == LEADING_ZERO_COUNT && !ctrl_q.dest_is_pc
			|=> ((result_q == 32'h0000_0020) ? ($past(source_q) == 32'h0000_0000)
			: (result_q < 32'h0000_0020 && ($past(source_q) >> (5'h1F - result_q[4:0])) == 32'h0000_0001))
			&& $stable(flags_q);
	endproperty
	a_clz: assert property (p_clz) else $error("leading zero count wrong"); // RULE10 RULE11

	property p_cmp;
		exec_q && ctrl_q.op == COMPARE_BY_SUBTRACT |=> $stable(result_q) && $stable(pc_q)
			&& flags_q.z == ($past(first_operand_q) == $past(flex_val)) && flags_q.c == ($past(first_operand_q) >= $past(flex_val));
	endproperty
	a_cmp: assert property (p_cmp) else $error("compare by subtract wrong"); // RULE12 RULE14

	property p_cmn;
		exec_q && ctrl_q.op == COMPARE_BY_ADD |=> $stable(result_q)
			&& flags_q.z == (($past(first_operand_q) + $past(flex_val)) == 32'h0000_0000);
	endproperty
	a_cmn: assert property (p_cmn) else $error("compare by add wrong"); // RULE13 RULE14

	property p_mvn;
		exec_q && ctrl_q.op == INVERTED_COPY && !ctrl_q.dest_is_pc |=> result_q == ~$past(flex_val);
	endproperty
	a_mvn: assert property (p_mvn) else $error("inverted copy wrong"); // RULE17

	property p_pc;
		exec_q && writes_dest && ctrl_q.dest_is_pc |=> redirect_o && !pc_o[0] && pc_o[31:1] == $past(alu_val[31:1])
			##1 !redirect_o;
	endproperty
	a_pc: assert property (p_pc) else $error("program counter redirect wrong"); // RULE19

	property p_no_flags;
		exec_q && is_logic && !ctrl_q.set_flags |=> $stable(flags_q);
	endproperty
	a_no_flags: assert property (p_no_flags) else $error("flags changed without update"); // RULE24

	property p_rrx;
		exec_q && ctrl_q.rotate_through_carry && ctrl_q.op == COPY_OP && ctrl_q.set_flags && !ctrl_q.dest_is_pc
			|=> result_q == {$past(flags_q.c), $past(source_q[31:1])} && flags_q.c == $past(source_q[0]);
	endproperty
	a_rrx: assert property (p_rrx) else $error("rotate through carry wrong"); // RULE7 RULE23

	property p_src_kept;
		exec_q |=> $stable(source_q) && $stable(first_operand_q);
	endproperty
	a_src_kept: assert property (p_src_kept) else $error("source changed by execution"); // RULE8

	property p_wide;
		exec_q && ctrl_q.op == WIDE_IMMEDIATE_COPY && !ctrl_q.dest_is_pc |=> result_q[31:16] == 16'h0000;
	endproperty
	a_wide: assert property (p_wide) else $error("wide immediate not zero extended"); // RULE16

	property p_bus;
		read_i && !ack_q |-> waitrequest_o ##1 !waitrequest_o;
	endproperty
	a_bus: assert property (p_bus) else $error("bus answer not after one wait");

	c_cmp: cover property (exec_q && ctrl_q.op == COMPARE_BY_SUBTRACT);
	c_redirect: cover property (redirect_o);
	c_big_shift: cover property (exec_q && ctrl_q.amount_by_reg && amount > `SHIFT_BEYOND);
	c_sbc: cover property (exec_q && ctrl_q.op == SUBTRACT_WITH_BORROW && !flags_q.c);

endmodule : integer_logic_shift_move_alu

`default_nettype wire

// *** tb/decoder_model.sv ***
// Decoder and register file side: masters the datapath's Avalon-MM bus.
// Assumes one clock and that the bench calls the tasks only after reset.
`timescale 1ns/1ns
`include "alu_consts.svh"
`default_nettype none

module decoder_model
	import alu_pkg::*;
(
	input wire logic clk_i,
	input wire logic [31:0] readdata_i,
	input wire logic waitrequest_i,
	output logic [4:0] address_o,
	output logic read_o,
	output logic write_o,
	output logic [31:0] writedata_o,
	output logic [3:0] byteenable_o
);
	// Idle bus from time zero
	initial begin
		address_o = 5'h00;
		read_o = 1'b0;
		write_o = 1'b0;
		writedata_o = 32'h0000_0000;
		byteenable_o = 4'hF;
	end

	// Request stays put until waitrequest is seen low at a rising edge
	// No cycle count assumed; only the bench watchdog ends a hung wait
	task automatic wait_ack();
		do begin
			@(posedge clk_i);
		end while (waitrequest_i !== 1'b0);
	endtask : wait_ack

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_i);
		address_o <= a;
		writedata_o <= d;
		write_o <= 1'b1;
		wait_ack();
		write_o <= 1'b0;
		writedata_o <= ~d; // Stale data must not look valid
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk_i);
		address_o <= a;
		read_o <= 1'b1;
		wait_ack();
		d = readdata_i;
		read_o <= 1'b0;
	endtask : rd

	// Operands first, control word last since it launches the operation
	task automatic exec(input ctrl_t c, input logic [31:0] a, input logic [31:0] b, input logic [31:0] s);
		ctrl_t k;
		k = c;
		if (c.dest_is_pc) k = ctrl_t'({c[31:16], 12'h040, c[3:0]});
		wr(`OFS_FIRST_OPERAND, a);
		wr(`OFS_SOURCE, b);
		wr(`OFS_SHIFT_AMOUNT, s);
		wr(`OFS_CONTROL, k);
	endtask : exec
endmodule : decoder_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the logic, shift and copy datapath.
// Assumes the decoder model masters the bus; expectations come from ref_op.
`timescale 1ns/1ns
`include "alu_consts.svh"
`default_nettype none

module tb_top;
	import alu_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [4:0] address;
	logic read;
	logic write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic [31:0] pc;
	logic [3:0] byteenable;
	logic [3:0] flags;
	logic waitrequest;
	logic redirect;
	logic [31:0] er = 32'h0;
	logic [31:0] ep = 32'h0;
	logic [31:0] n_redir = 32'h0;
	flags_t ef = 4'h0;
	int n_errors = 0;
	int num_checks = 0;
	logic [31:0] amts [8] = '{32'h0, 32'h1, 32'h1F, 32'h20, 32'h21, 32'hFF, 32'h0301, 32'hFFFF_FF00};
	logic [4:0] imms [3] = '{5'h00, 5'h01, 5'h1F};
	logic [31:0] va [4] = '{32'h0, 32'h1, 32'h8000_0000, 32'h0001_FFFF};
	logic [31:0] vb [4] = '{32'h5, 32'h7FFF_FFFF, 32'h0, 32'h8000_0000};

	always #50 clk_i = ~clk_i;
	// Pulse counter, so a stuck-high redirect shows as extra counts
	always @(posedge clk_i) if (redirect === 1'b1) n_redir++;

	integer_logic_shift_move_alu dut (.clk_i(clk_i), .rst_i(rst_i), .address_i(address), .read_i(read),
		.write_i(write), .writedata_i(writedata), .byteenable_i(byteenable), .readdata_o(readdata),
		.waitrequest_o(waitrequest), .pc_o(pc), .redirect_o(redirect), .flags_o(flags));
	decoder_model p (.clk_i(clk_i), .readdata_i(readdata), .waitrequest_i(waitrequest), .address_o(address),
		.read_o(read), .write_o(write), .writedata_o(writedata), .byteenable_o(byteenable));

	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk32

	task automatic chk4(input logic [3:0] g, input logic [3:0] e);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk4

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict

	function automatic ctrl_t mk(alu_op_t o, shift_kind_t k, logic byreg, logic rtc, logic sf, logic [4:0] imm,
		logic to_pc, logic [15:0] w);
		mk = '{wide_immediate: w, imm_amount: imm, dest_is_pc: to_pc, set_flags: sf, rotate_through_carry: rtc,
			amount_by_reg: byreg, reserved: 1'b0, shift_kind: k, op: o};
	endfunction : mk

	// Independent model of flex operand, result, flags and pc
	task automatic ref_op(input ctrl_t c, input logic [31:0] a, input logic [31:0] b, input logic [31:0] s);
		logic [63:0] t;
		logic [7:0] amt;
		logic [31:0] f;
		logic [31:0] r;
		logic [31:0] g;
		logic [32:0] w;
		logic co;
		logic vo;
		amt = c.amount_by_reg ? s[7:0] : {3'h0, c.imm_amount};
		if (!c.amount_by_reg && amt == 8'h00 && c.shift_kind inside {LOGIC_SHIFT_RIGHT, ARITH_SHIFT_RIGHT}) amt = 8'h20;
		case (c.shift_kind)
			LOGIC_SHIFT_LEFT: t = {32'h0, b} << amt;
			LOGIC_SHIFT_RIGHT: t = {b, 32'h0} >> amt;
			ARITH_SHIFT_RIGHT: t = $signed({b, 32'h0}) >>> amt;
			default: t = {b, b} >> amt[4:0];
		endcase
		f = (c.shift_kind inside {LOGIC_SHIFT_LEFT, ROTATE_RIGHT}) ? t[31:0] : t[63:32];
		co = (c.shift_kind == LOGIC_SHIFT_LEFT) ? t[32] : (c.shift_kind == ROTATE_RIGHT) ? f[31] : t[31];
		if (amt == 8'h00) f = b;
		if (amt == 8'h00) co = ef.c;
		if (c.rotate_through_carry) f = {ef.c, b[31:1]};
		if (c.rotate_through_carry) co = b[0];
		vo = ef.v;
		case (c.op)
			BITWISE_CONJUNCTION: r = a & f;
			BITWISE_DISJUNCTION: r = a | f;
			BITWISE_EXCLUSIVE_DISJUNCTION: r = a ^ f;
			BIT_CLEAR_OP: r = a & ~f;
			DISJUNCTION_WITH_COMPLEMENT: r = a | ~f;
			COPY_OP: r = f;
			INVERTED_COPY: r = ~f;
			WIDE_IMMEDIATE_COPY: begin
				r = {16'h0000, c.wide_immediate};
				co = ef.c;
			end
			LEADING_ZERO_COUNT: begin
				r = 32'h20;
				for (int i = 0; i < 32; i++) if (b[i]) r = 32'(31 - i);
			end
			default: begin
				g = (c.op inside {COMPARE_BY_SUBTRACT, SUBTRACT_WITH_BORROW}) ? ~f : f;
				w = {1'b0, a} + {1'b0, g} + ((c.op == COMPARE_BY_SUBTRACT) ? 33'h1 : (c.op == COMPARE_BY_ADD) ? 33'h0 : {32'h0, ef.c});
				r = w[31:0];
				co = w[32];
				vo = (a[31] == g[31]) && (r[31] != a[31]);
			end
		endcase
		if (c.op inside {COMPARE_BY_SUBTRACT, COMPARE_BY_ADD} || (c.set_flags && c.op != LEADING_ZERO_COUNT)) ef = '{n: r[31], z: r == 32'h0, c: co, v: vo};
		if (c.dest_is_pc) ep = {f[31:1], 1'b0};
		else if (!(c.op inside {COMPARE_BY_SUBTRACT, COMPARE_BY_ADD})) er = r;
	endtask : ref_op

	// One operation, then result, flags, pc and untouched source
	task automatic run(input ctrl_t c, input logic [31:0] a, input logic [31:0] b, input logic [31:0] s);
		logic [31:0] got;
		ref_op(c, a, b, s);
		p.exec(c, a, b, s);
		p.rd(`OFS_RESULT, got);
		chk32(got, er);
		chk4(flags, ef);
		chk32(pc, ep);
		p.rd(`OFS_SOURCE, got);
		chk32(got, b);
	endtask : run

	task automatic setf(input logic [3:0] f);
		p.wr(`OFS_FLAGS, {28'h0, f});
		ef = f;
	endtask : setf

	initial begin
		logic [31:0] r;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		p.rd(`OFS_FLAGS, r);
		chk32(r, 32'h0);
		chk4(flags, 4'h0);
		$display("test reset done");
		for (int o = 0; o < 5; o++) begin
			setf(4'h1);
			run(mk(alu_op_t'(o), ROTATE_RIGHT, 0, 0, 1, 5'h04, 0, 16'h0), 32'hF0F0_1234, 32'h8765_43A1, 0);
			setf(4'hF);
			run(mk(alu_op_t'(o), LOGIC_SHIFT_LEFT, 0, 0, 0, 5'h00, 0, 16'h0), 32'h0F0F_0000, 32'hFFFF_0000, 0);
		end
		$display("test logic done");
		for (int k = 0; k < 4; k++) begin
			foreach (amts[j]) run(mk(COPY_OP, shift_kind_t'(k), 1, 0, 1, 5'h00, 0, 16'h0), 0, 32'hC000_0003, amts[j]);
			foreach (imms[j]) run(mk(COPY_OP, shift_kind_t'(k), 0, 0, 1, imms[j], 0, 16'h0), 0, 32'h8000_0001, 0);
		end
		for (int i = 0; i < 2; i++) begin
			setf({2'b00, i[0], 1'b0});
			run(mk(COPY_OP, LOGIC_SHIFT_LEFT, 0, 1, 1, 5'h00, 0, 16'h0), 0, 32'h0000_0003, 0);
		end
		$display("test shift done");
		run(mk(INVERTED_COPY, LOGIC_SHIFT_RIGHT, 0, 0, 1, 5'h04, 0, 16'h0), 0, 32'h0000_00F0, 0);
		run(mk(WIDE_IMMEDIATE_COPY, LOGIC_SHIFT_LEFT, 0, 0, 1, 5'h03, 0, 16'hFFFF), 0, 32'h1, 0);
		run(mk(WIDE_IMMEDIATE_COPY, LOGIC_SHIFT_LEFT, 0, 0, 1, 5'h00, 0, 16'h0000), 0, 32'h1, 0);
		setf(4'hA);
		foreach (va[j]) run(mk(LEADING_ZERO_COUNT, LOGIC_SHIFT_LEFT, 0, 0, 1, 5'h03, 0, 16'h0), 0, va[j], 0);
		$display("test copy and count done");
		setf(4'h0);
		foreach (vb[j]) begin
			run(mk(COMPARE_BY_SUBTRACT, LOGIC_SHIFT_LEFT, 0, 0, 0, 5'h00, 0, 16'h0), vb[j], 32'h5, 0);
			run(mk(COMPARE_BY_ADD, LOGIC_SHIFT_LEFT, 0, 0, 0, 5'h00, 0, 16'h0), vb[j], 32'h1, 0);
		end
		setf(4'h0);
		run(mk(ADD_WITH_CARRY, LOGIC_SHIFT_LEFT, 0, 0, 1, 5'h00, 0, 16'h0), 32'hFFFF_FFFF, 32'h1, 0);
		run(mk(ADD_WITH_CARRY, LOGIC_SHIFT_LEFT, 0, 0, 0, 5'h00, 0, 16'h0), 32'h2, 32'h3, 0);
		setf(4'h0);
		run(mk(SUBTRACT_WITH_BORROW, LOGIC_SHIFT_LEFT, 0, 0, 1, 5'h00, 0, 16'h0), 32'h5, 32'h3, 0);
		run(mk(SUBTRACT_WITH_BORROW, LOGIC_SHIFT_LEFT, 0, 0, 0, 5'h00, 0, 16'h0), 32'h5, 32'h3, 0);
		$display("test compare and carry done");
		// Read-only result ignores writes
		p.wr(`OFS_RESULT, 32'h5A5A_5A5A);
		p.rd(`OFS_RESULT, r);
		chk32(r, er);
		run(mk(COPY_OP, LOGIC_SHIFT_LEFT, 0, 0, 0, 5'h00, 1, 16'h0), 0, 32'h0000_1235, 0);
		chk32(n_redir, 32'h1);
		p.rd(`OFS_STATUS, r);
		chk32(r, 32'h2);
		$display("test redirect done");
		give_verdict();
	end

	// Whole run needs about 1440 cycles
	initial begin
		repeat (30000) @(posedge clk_i);
		n_errors++;
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
